// [core/fmc_pkg.sv]
package fmc_pkg;

   // register byte offsets (axi4-lite, one word each)
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_CAR_SHAPE  = 8'h04;
   localparam logic [7:0] ADDR_CAR_FREQ   = 8'h08;
   localparam logic [7:0] ADDR_DEV        = 8'h0c;
   localparam logic [7:0] ADDR_MOD_SHAPE  = 8'h10;
   localparam logic [7:0] ADDR_MOD_RATE   = 8'h14;
   localparam logic [7:0] ADDR_FSK_RATE   = 8'h18;
   localparam logic [7:0] ADDR_STATUS     = 8'h1c;
   localparam logic [7:0] ADDR_HOP_FREQ   = 8'h20;
   localparam logic [7:0] ADDR_ARB_LEN    = 8'h24;
   localparam logic [7:0] ADDR_ARB_DATA   = 8'h28;
   localparam logic [7:0] ADDR_ARB_POINTS = 8'h2c;

   // control register bit positions
   localparam int CTRL_FM      = 0;
   localparam int CTRL_FSK     = 1;
   localparam int CTRL_AM      = 2;
   localparam int CTRL_SWEEP   = 3;
   localparam int CTRL_BURST   = 4;
   localparam int CTRL_FM_EXT  = 5;
   localparam int CTRL_FSK_EXT = 6;

   // status register bit positions
   localparam int STAT_SHAPE_REJ = 0;
   localparam int STAT_DEV_CLIP  = 1;
   localparam int STAT_HOP       = 2;

   // carrier shape codes; pulse, noise and dc are refused
   localparam logic [2:0] CAR_SINE   = 3'h0;
   localparam logic [2:0] CAR_SQUARE = 3'h1;
   localparam logic [2:0] CAR_RAMP   = 3'h2;
   localparam logic [2:0] CAR_ARB    = 3'h3;
   localparam logic [2:0] CAR_PULSE  = 3'h4;
   localparam logic [2:0] CAR_NOISE  = 3'h5;
   localparam logic [2:0] CAR_DC     = 3'h6;

   // internal modulating shape codes
   localparam logic [2:0] MOD_SINE         = 3'h0;
   localparam logic [2:0] MOD_SQUARE       = 3'h1;
   localparam logic [2:0] MOD_RAMP         = 3'h2;
   localparam logic [2:0] MOD_FALLING_RAMP = 3'h3;
   localparam logic [2:0] MOD_TRIANGLE     = 3'h4;
   localparam logic [2:0] MOD_NOISE        = 3'h5;
   localparam logic [2:0] MOD_ARB          = 3'h6;

   // frequency limits in hz
   localparam logic [31:0] CAR_MIN_HZ      = 32'd5;
   localparam logic [31:0] FMAX_SINE_HZ    = 32'd80_000_000;
   localparam logic [31:0] FMAX_RAMP_HZ    = 32'd1_000_000;
   localparam logic [31:0] FMAX_ARB_HZ     = 32'd25_000_000;
   localparam logic [31:0] DEV_HEADROOM_HZ = 32'd100_000;
   localparam logic [31:0] DEV_MIN_HZ      = 32'd5;
   localparam logic [31:0] DEV_CAP_SINE_HZ = 32'd40_050_000;
   localparam logic [31:0] DEV_CAP_RAMP_HZ = 32'd550_000;
   localparam logic [31:0] DEV_CAP_ARB_HZ  = 32'd12_550_000;
   localparam logic [31:0] HOP_MIN_HZ      = 32'd1;
   localparam logic [31:0] CAR_RST_HZ      = 32'd1_000;
   localparam logic [31:0] DEV_RST_HZ      = 32'd100;
   localparam logic [31:0] HOP_RST_HZ      = 32'd100;

   // rates in millihertz
   localparam logic [31:0] RATE_MIN_MHZ     = 32'd2;
   localparam logic [31:0] MOD_RATE_MAX_MHZ = 32'd20_000_000;
   localparam logic [31:0] FSK_RATE_MAX_MHZ = 32'd100_000_000;
   localparam logic [31:0] MOD_RATE_RST_MHZ = 32'd10_000;
   localparam logic [31:0] FSK_RATE_RST_MHZ = 32'd10_000;

   // phase accumulators: increment per cycle = rate_mhz * 2^48 / (clk_hz * 1000)
   localparam longint    CLK_HZ          = 100_000_000;
   localparam int        PHASE_W         = 48;
   localparam logic [47:0] PHASE_INC_SCALE =
      48'((64'd1 << 48) / (64'(CLK_HZ) * 64'd1000));

   // arbitrary modulating waveform store
   localparam int          ARB_AW       = 13;
   localparam logic [16:0] ARB_LEN_MAX  = 17'd65536;
   localparam logic [16:0] ARB_DEPTH    = 17'd8192;
   localparam logic [15:0] LFSR_SEED    = 16'hace1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {MODE_OFF, MODE_AM, MODE_FM, MODE_FSK} fmc_mode_type;

endpackage

// [core/fmc_wave_mem.sv]
`timescale 1ns/1ps
module fmc_wave_mem
   #(
   parameter int AW = 13,
   parameter int DW = 16
   )
   (
   // clock
   input  wire logic          i_clk,
   // write side
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [DW-1:0] i_wdata,
   // read side
   input  wire logic [AW-1:0] i_raddr,
   output logic      [DW-1:0] o_rdata
   );

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge i_clk)
   begin
      if (i_we)
      begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end

endmodule // fmc_wave_mem

// [core/fmc_freq_mod_ctrl.sv]
// Notes on behaviour
// - only one modulation mode active; enabling fm drops the previous one
// - enabling fm switches sweep and burst off
// - carrier shape sine, square, ramp or arb, sine at reset; others refused
// - carrier 5 hz up to shape maximum, 1 khz at reset
// - with fm on, deviation never exceeds carrier frequency
// - with fm on, carrier plus deviation kept within shape maximum plus 100 khz
// - internal modulating shape selectable among seven, sine at reset
// - square 50% duty, ramp rising, triangle 50%, falling ramp fixed
// - arbitrary modulating wave decimated down to at most 8k points
// - internal modulating rate 2 mhz to 20 khz, 10 hz at reset
// - deviation 5 hz to 40.05 mhz, 550 khz ramp, 12.55 mhz arb, 100 hz
// - modulation source internal or external, internal at reset
// - external sample scales offset: full positive gives full deviation above
// - output frequency follows current settings as soon as fm is on
// - keying alternates carrier and hop frequency, internal or external pacing
// - enabling keying drops other modulation and switches sweep, burst off
// - external keying: trigger low gives carrier, high gives hop
// - internal keying follows 50% square, 2 mhz to 100 khz, 10 hz at reset
`timescale 1ns/1ps
module fmc_freq_mod_ctrl
   import fmc_pkg::*;
   (
   // clock and reset
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RESET_N,
   // axi4-lite write
   input  wire logic [7:0]  I_AXI_AWADDR,
   input  wire logic        I_AXI_AWVALID,
   output logic             O_AXI_AWREADY,
   input  wire logic [31:0] I_AXI_WDATA,
   input  wire logic [3:0]  I_AXI_WSTRB,
   input  wire logic        I_AXI_WVALID,
   output logic             O_AXI_WREADY,
   output logic [1:0]       O_AXI_BRESP,
   output logic             O_AXI_BVALID,
   input  wire logic        I_AXI_BREADY,
   // axi4-lite read
   input  wire logic [7:0]  I_AXI_ARADDR,
   input  wire logic        I_AXI_ARVALID,
   output logic             O_AXI_ARREADY,
   output logic [31:0]      O_AXI_RDATA,
   output logic [1:0]       O_AXI_RRESP,
   output logic             O_AXI_RVALID,
   input  wire logic        I_AXI_RREADY,
   // modulation inputs
   input  wire logic [15:0] I_EXT_MOD,
   input  wire logic        I_EXT_TRIG,
   // synthesizer side
   output logic [31:0]      O_OUT_FREQ_HZ,
   output logic [1:0]       O_MOD_MODE,
   output logic             O_SWEEP_ON,
   output logic             O_BURST_ON,
   output logic [2:0]       O_CARRIER_SHAPE,
   output logic [15:0]      O_MOD_SAMPLE,
   output logic             O_HOP_ACTIVE
   );

   logic         awready_reg, awready_next, bvalid_reg, bvalid_next;
   logic         arready_reg, arready_next, rvalid_reg, rvalid_next;
   logic [1:0]   bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0]  rdata_reg, rdata_next;
   fmc_mode_type mode_reg, mode_next;
   logic         sweep_reg, sweep_next, burst_reg, burst_next;
   logic         fm_ext_reg, fm_ext_next, fsk_ext_reg, fsk_ext_next;
   logic [2:0]   shape_reg, shape_next, mshape_reg, mshape_next;
   logic [31:0]  car_reg, car_next, dev_reg, dev_next, hop_reg, hop_next;
   logic [31:0]  mrate_reg, mrate_next, frate_reg, frate_next;
   logic         rej_reg, rej_next, clip_reg, clip_next;
   logic [16:0]  alen_reg, alen_next, acc_reg, acc_next;
   logic [13:0]  points_reg, points_next;
   logic [PHASE_W-1:0] ph_reg [2];
   logic [PHASE_W-1:0] ph_next [2];
   logic [31:0]  rate_sel [2];
   logic [15:0]  lfsr_reg, lfsr_next, wave_reg, wave_next, arb_rdata;
   logic         hop_reg_sel, hop_sel_next;
   logic [31:0]  out_reg, out_next;
   logic         mem_we;
   logic [12:0]  mem_waddr, mem_raddr;
   logic [31:0]  wd, car_req, dev_req, hop_req, lim, clr;
   logic [17:0]  acc_sum;

   function automatic logic [31:0] clip(input logic [31:0] v, lo, hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [31:0] fmax(input logic [2:0] s);
      return (s == CAR_RAMP) ? FMAX_RAMP_HZ : ((s == CAR_ARB) ? FMAX_ARB_HZ : FMAX_SINE_HZ);
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= ADDR_ARB_POINTS);
   endfunction

   function automatic logic [31:0] reg_read(input logic [7:0] a);
      case (a)
         ADDR_CTRL:       return {25'h0, fsk_ext_reg, fm_ext_reg, burst_reg, sweep_reg,
                                  mode_reg == MODE_AM, mode_reg == MODE_FSK, mode_reg == MODE_FM};
         ADDR_CAR_SHAPE:  return {29'h0, shape_reg};
         ADDR_CAR_FREQ:   return car_reg;
         ADDR_DEV:        return dev_reg;
         ADDR_MOD_SHAPE:  return {29'h0, mshape_reg};
         ADDR_MOD_RATE:   return mrate_reg;
         ADDR_FSK_RATE:   return frate_reg;
         ADDR_STATUS:     return {29'h0, hop_reg_sel, clip_reg, rej_reg};
         ADDR_HOP_FREQ:   return hop_reg;
         ADDR_ARB_LEN:    return {15'h0, alen_reg};
         ADDR_ARB_POINTS: return {18'h0, points_reg};
         default:         return 32'h0;
      endcase
   endfunction

   // bus slave: write taken when address and data are both offered
   always_comb
   begin
      awready_next = I_AXI_AWVALID && I_AXI_WVALID && !awready_reg && !bvalid_reg;
      bvalid_next  = bvalid_reg ? !I_AXI_BREADY : awready_reg;
      bresp_next   = awready_reg ? (addr_ok(I_AXI_AWADDR) ? RESP_OKAY : RESP_SLVERR) : bresp_reg;
      arready_next = I_AXI_ARVALID && !arready_reg && !rvalid_reg;
      rvalid_next  = rvalid_reg ? !I_AXI_RREADY : arready_reg;
      rdata_next   = arready_reg ? reg_read(I_AXI_ARADDR) : rdata_reg;
      rresp_next   = arready_reg ? (addr_ok(I_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR) : rresp_reg;
      wd  = reg_read(I_AXI_AWADDR);
      clr = 32'h0;
      for (int b = 0; b < 4; b++)
      begin
         if (I_AXI_WSTRB[b])
         begin
            wd[8*b+:8]  = I_AXI_WDATA[8*b+:8];
            clr[8*b+:8] = I_AXI_WDATA[8*b+:8];
         end
      end
   end

   // configuration registers
   always_comb
   begin
      mode_next = mode_reg;
      sweep_next = sweep_reg;
      burst_next = burst_reg;
      fm_ext_next = fm_ext_reg;
      fsk_ext_next = fsk_ext_reg;
      shape_next = shape_reg;
      mshape_next = mshape_reg;
      mrate_next = mrate_reg;
      frate_next = frate_reg;
      car_req = car_reg;
      dev_req = dev_reg;
      hop_req = hop_reg;
      rej_next = rej_reg;
      clip_next = clip_reg;
      if (awready_reg)
      begin
         case (I_AXI_AWADDR)
            ADDR_CTRL:
            begin
               fm_ext_next  = wd[CTRL_FM_EXT];
               fsk_ext_next = wd[CTRL_FSK_EXT];
               sweep_next   = wd[CTRL_SWEEP];
               burst_next   = wd[CTRL_BURST] && !wd[CTRL_SWEEP];
               if (wd[CTRL_FM] || wd[CTRL_FSK] || wd[CTRL_AM])
               begin
                  mode_next  = wd[CTRL_FM] ? MODE_FM : (wd[CTRL_FSK] ? MODE_FSK : MODE_AM);
                  sweep_next = 1'b0;
                  burst_next = 1'b0;
               end
               else
               begin
                  mode_next = MODE_OFF;
               end
            end
            ADDR_CAR_SHAPE:
            begin
               if (wd[2:0] <= CAR_ARB && wd[31:3] == 29'h0)
                  shape_next = wd[2:0];
               else
                  rej_next = 1'b1;
            end
            ADDR_CAR_FREQ: car_req = wd;
            ADDR_DEV:      dev_req = wd;
            ADDR_HOP_FREQ: hop_req = wd;
            ADDR_MOD_SHAPE:
            begin
               if (wd[2:0] <= MOD_ARB && wd[31:3] == 29'h0)
                  mshape_next = wd[2:0];
               else
                  rej_next = 1'b1;
            end
            ADDR_MOD_RATE: mrate_next = clip(wd, RATE_MIN_MHZ, MOD_RATE_MAX_MHZ);
            ADDR_FSK_RATE: frate_next = clip(wd, RATE_MIN_MHZ, FSK_RATE_MAX_MHZ);
            ADDR_STATUS:
            begin
               rej_next  = rej_reg && !clr[STAT_SHAPE_REJ];
               clip_next = clip_reg && !clr[STAT_DEV_CLIP];
            end
            default: ;
         endcase
      end
      car_next = clip(car_req, CAR_MIN_HZ, fmax(shape_next));
      hop_next = clip(hop_req, HOP_MIN_HZ, fmax(shape_next));
      lim = (shape_next == CAR_RAMP) ? DEV_CAP_RAMP_HZ :
            ((shape_next == CAR_ARB) ? DEV_CAP_ARB_HZ : DEV_CAP_SINE_HZ);
      if (mode_next == MODE_FM)
      begin
         if (car_next < lim)
            lim = car_next;
         if (fmax(shape_next) + DEV_HEADROOM_HZ - car_next < lim)
            lim = fmax(shape_next) + DEV_HEADROOM_HZ - car_next;
      end
      dev_next = clip(dev_req, DEV_MIN_HZ, lim);
      if (dev_next != dev_req)
         clip_next = 1'b1;
   end

   // decimate a long record into the 8k store
   always_comb
   begin
      alen_next   = alen_reg;
      acc_next    = acc_reg;
      points_next = points_reg;
      mem_we      = 1'b0;
      mem_waddr   = points_reg[12:0];
      acc_sum     = {1'b0, acc_reg} + {1'b0, ARB_DEPTH};
      if (awready_reg && I_AXI_AWADDR == ADDR_ARB_LEN)
      begin
         alen_next   = 17'(clip(wd, 32'd1, {15'h0, ARB_LEN_MAX}));
         acc_next    = 17'h0;
         points_next = 14'h0;
      end
      else if (awready_reg && I_AXI_AWADDR == ADDR_ARB_DATA)
      begin
         if (acc_sum >= {1'b0, alen_reg})
         begin
            acc_next = 17'(acc_sum - {1'b0, alen_reg});
            if ({3'h0, points_reg} < ARB_DEPTH)
            begin
               mem_we      = 1'b1;
               points_next = points_reg + 14'h1;
            end
         end
         else
         begin
            acc_next = acc_sum[16:0];
         end
      end
   end

   fmc_wave_mem #(.AW(ARB_AW), .DW(16)) u_wave_mem
   (
      .i_clk   (I_CORE_CLK),
      .i_we    (mem_we),
      .i_waddr (mem_waddr),
      .i_wdata (wd[15:0]),
      .i_raddr (mem_raddr),
      .o_rdata (arb_rdata)
   );

   // phase accumulators: 0 modulating rate, 1 keying rate
   assign rate_sel[0] = mrate_reg;
   assign rate_sel[1] = frate_reg;
   for (genvar g = 0; g < 2; g++)
   begin : g_phase
      always_comb
      begin
         ph_next[g] = ph_reg[g] + 48'(48'(rate_sel[g]) * PHASE_INC_SCALE);
      end
      always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
      begin
         if (!I_RESET_N)
            ph_reg[g] <= '0;
         else
            ph_reg[g] <= ph_next[g];
      end
   end

   // modulating sample and output frequency
   logic        [15:0] u, tri_u;
   logic signed [16:0] s, a;
   logic signed [33:0] sp;
   logic signed [48:0] offs;
   logic signed [33:0] sum;
   always_comb
   begin
      u         = ph_reg[0][47:32];
      s         = $signed({1'b0, u}) - 17'sd32768;
      a         = s[16] ? -s : s;
      sp        = 34'(s) * 34'(17'sd32768 - a);
      tri_u     = u[15] ? ~(u << 1) : (u << 1);
      mem_raddr = 13'((30'(u) * 30'(points_reg)) >> 16);
      lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      case (mshape_reg)
         MOD_SINE:         wave_next = (sp >>> 13) > 34'sd32767 ? 16'h7fff : 16'(sp >>> 13);
         MOD_SQUARE:       wave_next = u[15] ? 16'h8001 : 16'h7fff;
         MOD_RAMP:         wave_next = u ^ 16'h8000;
         MOD_FALLING_RAMP: wave_next = ~(u ^ 16'h8000);
         MOD_TRIANGLE:     wave_next = tri_u ^ 16'h8000;
         MOD_NOISE:        wave_next = lfsr_reg;
         MOD_ARB:          wave_next = arb_rdata;
         default:          wave_next = 16'h0;
      endcase
      // external sample replaces the internal one
      if (fm_ext_reg)
         wave_next = I_EXT_MOD;
      hop_sel_next = fsk_ext_reg ? I_EXT_TRIG : ph_reg[1][47];
      offs = 49'($signed({1'b0, dev_reg})) * 49'($signed(wave_reg));
      sum  = $signed({2'b00, car_reg}) + 34'(offs >>> 15);
      case (mode_reg)
         MODE_FM:  out_next = sum[31:0];
         MODE_FSK: out_next = hop_reg_sel ? hop_reg : car_reg;
         default:  out_next = car_reg;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         {awready_reg, bvalid_reg, arready_reg, rvalid_reg} <= 4'h0;
         {bresp_reg, rresp_reg} <= {RESP_OKAY, RESP_OKAY};
         rdata_reg <= 32'h0;
         mode_reg <= MODE_OFF;
         {sweep_reg, burst_reg, fm_ext_reg, fsk_ext_reg, rej_reg, clip_reg} <= 6'h0;
         shape_reg <= CAR_SINE;
         mshape_reg <= MOD_SINE;
         car_reg <= CAR_RST_HZ;
         dev_reg <= DEV_RST_HZ;
         hop_reg <= HOP_RST_HZ;
         mrate_reg <= MOD_RATE_RST_MHZ;
         frate_reg <= FSK_RATE_RST_MHZ;
         alen_reg <= ARB_DEPTH;
         acc_reg <= 17'h0;
         points_reg <= 14'h0;
         lfsr_reg <= LFSR_SEED;
         wave_reg <= 16'h0;
         hop_reg_sel <= 1'b0;
         out_reg <= CAR_RST_HZ;
      end
      else
      begin
         {awready_reg, bvalid_reg, arready_reg, rvalid_reg} <=
            {awready_next, bvalid_next, arready_next, rvalid_next};
         {bresp_reg, rresp_reg} <= {bresp_next, rresp_next};
         rdata_reg <= rdata_next;
         mode_reg <= mode_next;
         {sweep_reg, burst_reg, fm_ext_reg, fsk_ext_reg, rej_reg, clip_reg} <=
            {sweep_next, burst_next, fm_ext_next, fsk_ext_next, rej_next, clip_next};
         shape_reg <= shape_next;
         mshape_reg <= mshape_next;
         car_reg <= car_next;
         dev_reg <= dev_next;
         hop_reg <= hop_next;
         mrate_reg <= mrate_next;
         frate_reg <= frate_next;
         alen_reg <= alen_next;
         acc_reg <= acc_next;
         points_reg <= points_next;
         lfsr_reg <= lfsr_next;
         wave_reg <= wave_next;
         hop_reg_sel <= hop_sel_next;
         out_reg <= out_next;
      end
   end

   assign O_AXI_AWREADY   = awready_reg;
   assign O_AXI_WREADY    = awready_reg;
   assign O_AXI_BVALID    = bvalid_reg;
   assign O_AXI_BRESP     = bresp_reg;
   assign O_AXI_ARREADY   = arready_reg;
   assign O_AXI_RVALID    = rvalid_reg;
   assign O_AXI_RDATA     = rdata_reg;
   assign O_AXI_RRESP     = rresp_reg;
   assign O_OUT_FREQ_HZ   = out_reg;
   assign O_MOD_MODE      = mode_reg;
   assign O_SWEEP_ON      = sweep_reg;
   assign O_BURST_ON      = burst_reg;
   assign O_CARRIER_SHAPE = shape_reg;
   assign O_MOD_SAMPLE    = wave_reg;
   assign O_HOP_ACTIVE    = hop_reg_sel;

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESET_N);

   logic wr_ctrl;
   assign wr_ctrl = awready_reg && I_AXI_AWADDR == ADDR_CTRL;

   AST_FM_ENABLE_EXCL: assert property (wr_ctrl && wd[CTRL_FM] |=> mode_reg == MODE_FM)
      else $error("fm enable did not make fm the only mode");
   AST_FM_NO_SWEEP: assert property (mode_reg == MODE_FM |-> !sweep_reg && !burst_reg)
      else $error("sweep or burst active with fm");
   AST_SHAPE_REFUSE: assert property (awready_reg && I_AXI_AWADDR == ADDR_CAR_SHAPE && wd[2:0] > CAR_ARB
      |=> $stable(shape_reg) && rej_reg)
      else $error("illegal carrier shape accepted");
   AST_CAR_RANGE: assert property (car_reg >= CAR_MIN_HZ && car_reg <= fmax(shape_reg))
      else $error("carrier out of range");
   AST_DEV_LE_CAR: assert property (mode_reg == MODE_FM |-> dev_reg <= car_reg)
      else $error("deviation above carrier");
   AST_DEV_SUM: assert property (mode_reg == MODE_FM |->
      car_reg + dev_reg <= fmax(shape_reg) + DEV_HEADROOM_HZ)
      else $error("carrier plus deviation too high");
   AST_DEV_CAP: assert property (dev_reg >= DEV_MIN_HZ && (shape_reg != CAR_RAMP
      || dev_reg <= DEV_CAP_RAMP_HZ) && dev_reg <= DEV_CAP_SINE_HZ)
      else $error("deviation outside its range");
   AST_ARB_POINTS: assert property ({3'h0, points_reg} <= ARB_DEPTH)
      else $error("arbitrary store overfilled");
   AST_RATE_RANGE: assert property (mrate_reg >= RATE_MIN_MHZ
      && mrate_reg <= MOD_RATE_MAX_MHZ && frate_reg <= FSK_RATE_MAX_MHZ)
      else $error("rate out of range");
   AST_EXT_NEG: assert property (mode_reg == MODE_FM && fm_ext_reg && I_EXT_MOD[15]
      ##1 mode_reg == MODE_FM && $stable(car_reg) |=> O_OUT_FREQ_HZ < $past(car_reg))
      else $error("negative external level did not lower frequency");
   AST_FSK_EXT: assert property (mode_reg == MODE_FSK && fsk_ext_reg && I_EXT_TRIG
      ##1 mode_reg == MODE_FSK && $stable(hop_reg) |=> O_OUT_FREQ_HZ == $past(hop_reg))
      else $error("high trigger did not select hop frequency");

   COV_FM_ON: cover property (wr_ctrl && wd[CTRL_FM] ##1 mode_reg == MODE_FM);
   COV_DEV_CLIP: cover property ($rose(clip_reg));
   COV_HOP: cover property (mode_reg == MODE_FSK && $rose(hop_reg_sel));
   COV_ARB_FULL: cover property ({3'h0, points_reg} == ARB_DEPTH);

endmodule // fmc_freq_mod_ctrl

// [testbench/fmc_ext_source.sv]
`timescale 1ns/1ps
module fmc_ext_source
   (
   // clock
   input  wire logic        i_clk,
   // requested levels
   input  wire logic [15:0] i_level,
   input  wire logic        i_key,
   // modulation outputs
   output logic      [15:0] o_mod,
   output logic             o_trig
   );
   // level and key are passed on one clock later, unclamped
   always_ff @(posedge i_clk) o_mod <= i_level;
   always_ff @(posedge i_clk) o_trig <= i_key;
endmodule // fmc_ext_source

// [testbench/fmc_freq_mod_ctrl_bench.sv]
`timescale 1ns/1ps
module fmc_freq_mod_ctrl_bench;
   import fmc_pkg::*;
   logic        clk = 0, rst_n = 0, awv = 0, wv = 0, arv = 0, key = 0;
   logic [7:0]  aw = 0, ar = 0;
   logic [31:0] wd = 0, rdat, res, ofreq;
   logic [15:0] lvl = 0, emod, smp;
   logic [1:0]  bresp, rresp, rr, mode, wresp;
   logic [2:0]  shp;
   logic        awr, wr_r, bv, arr, rv, etrig, swp, bst, hop;
   int          num_errors = 0, compares = 0, n;
   always #5 clk = ~clk;
   fmc_ext_source src (.i_clk(clk), .i_level(lvl), .i_key(key), .o_mod(emod), .o_trig(etrig));
   fmc_freq_mod_ctrl dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_AXI_AWADDR(aw),
      .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_WDATA(wd), .I_AXI_WSTRB(4'hf),
      .I_AXI_WVALID(wv), .O_AXI_WREADY(wr_r), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bv),
      .I_AXI_BREADY(1'b1), .I_AXI_ARADDR(ar), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
      .O_AXI_RDATA(rdat), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rv), .I_AXI_RREADY(1'b1),
      .I_EXT_MOD(emod), .I_EXT_TRIG(etrig), .O_OUT_FREQ_HZ(ofreq), .O_MOD_MODE(mode),
      .O_SWEEP_ON(swp), .O_BURST_ON(bst), .O_CARRIER_SHAPE(shp), .O_MOD_SAMPLE(smp),
      .O_HOP_ACTIVE(hop));
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic hang;
      if (n >= 50)
      begin
         num_errors++;
         give_verdict();
      end
   endtask
   // write address and data offered together, bready held high throughout
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      n = 0;
      aw <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      do @(posedge clk); while ((awr & wr_r) !== 1'b1 && ++n < 50);
      awv <= 0;
      wv <= 0;
      do @(posedge clk); while (bv !== 1'b1 && ++n < 50);
      wresp = bresp;
      hang();
   endtask
   task automatic rd(input logic [7:0] a);
      n = 0;
      ar <= a;
      arv <= 1;
      do @(posedge clk); while (arr !== 1'b1 && ++n < 50);
      arv <= 0;
      do @(posedge clk); while (rv !== 1'b1 && ++n < 50);
      res = rdat;
      rr = rresp;
      hang();
   endtask
   task automatic pause;
      repeat (5) @(posedge clk);
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      rd(ADDR_CAR_FREQ);
      chk("carrier", res, 32'd1000);
      rd(ADDR_DEV);
      chk("deviation", res, 32'd100);
      $display("reset test done");
      wr(ADDR_CTRL, 32'h1d);
      pause();
      chk("fm mode", 32'({mode, swp, bst}), 32'({MODE_FM, 2'b00}));
      wr(ADDR_CTRL, 32'h1e);
      pause();
      chk("fsk mode", 32'({mode, swp, bst}), 32'({MODE_FSK, 2'b00}));
      $display("mode test done");
      for (int c = 4; c < 7; c++) wr(ADDR_CAR_SHAPE, 32'(c));
      rd(ADDR_CAR_SHAPE);
      chk("shape", res, 32'd0);
      rd(ADDR_STATUS);
      chk("refused", 32'(res[STAT_SHAPE_REJ]), 32'd1);
      wr(ADDR_CAR_SHAPE, 32'(CAR_RAMP));
      pause();
      chk("ramp", 32'(shp), 32'(CAR_RAMP));
      wr(ADDR_CAR_SHAPE, 32'(CAR_SINE));
      $display("shape test done");
      wr(ADDR_CTRL, 32'h21);
      wr(ADDR_CAR_FREQ, 32'd80_000_000);
      wr(ADDR_DEV, 32'd40_050_000);
      rd(ADDR_DEV);
      chk("dev top", res, 32'd100_000);
      wr(ADDR_CAR_FREQ, 32'd1000);
      rd(ADDR_DEV);
      chk("dev follow", res, 32'd1000);
      lvl <= 16'h7fff;
      pause();
      chk("ext full", ofreq, 32'd1999);
      chk("ext sample", 32'(smp), 32'h7fff);
      lvl <= 16'hc000;
      pause();
      chk("ext neg", ofreq, 32'd500);
      $display("fm test done");
      wr(ADDR_CTRL, 32'h42);
      key <= 1;
      pause();
      chk("hop", ofreq, 32'd100);
      chk("hop flag", 32'(hop), 32'd1);
      key <= 0;
      pause();
      chk("carrier", ofreq, 32'd1000);
      rd(8'h30);
      chk("unmapped", 32'(rr), 32'(RESP_SLVERR));
      wr(8'h31, 32'h0);
      chk("write resp", 32'(wresp), 32'(RESP_SLVERR));
      $display("keying test done");
      wr(ADDR_CTRL, 32'h02);
      wr(ADDR_FSK_RATE, 32'hffffffff);
      rd(ADDR_FSK_RATE);
      chk("keying rate", res, 32'd100_000_000);
      n = 0;
      repeat (2000) @(posedge clk) n += hop;
      chk("keying duty", 32'(n > 980 && n < 1020), 32'd1);
      wr(ADDR_MOD_RATE, 32'h0);
      rd(ADDR_MOD_RATE);
      chk("mod rate", res, 32'd2);
      wr(ADDR_MOD_SHAPE, 32'h7);
      rd(ADDR_MOD_SHAPE);
      chk("mod shape", res, 32'(MOD_SINE));
      wr(ADDR_MOD_SHAPE, 32'(MOD_SQUARE));
      wr(ADDR_CTRL, 32'h01);
      pause();
      chk("square", 32'(smp), 32'h7fff);
      chk("internal fm", ofreq, 32'd1999);
      wr(ADDR_ARB_LEN, 32'd16384);
      for (int i = 0; i < 4; i++) wr(ADDR_ARB_DATA, 32'(i));
      rd(ADDR_ARB_POINTS);
      chk("arb points", res, 32'd2);
      wr(ADDR_STATUS, 32'h1);
      rd(ADDR_STATUS);
      chk("refuse clear", 32'(res[STAT_SHAPE_REJ]), 32'd0);
      rst_n <= 0;
      @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      rd(ADDR_CTRL);
      chk("ctrl after reset", res, 32'h0);
      rd(ADDR_MOD_SHAPE);
      chk("mod shape reset", res, 32'(MOD_SINE));
      $display("modulation test done");
      give_verdict();
   end
endmodule // fmc_freq_mod_ctrl_bench
